/* File: design/xga_top.sv */
// Lane adapters for both directions and the two-input frame arbiter
//
// Operation
// - Each direction runs on its own interface clock
// - TX takes 64-bit stream, single-rate 64-bit lanes
// - TX leaves at least twelve idle bytes between frames
// - TX adds preamble and delimiter before payload
// - TX encodes data, control, start, terminate, idle
// - TX start character always in lane zero
// - RX delivers 64-bit stream without preamble
// - RX decodes control lanes into keep and last
// - RX accepts start in lane zero or four
// - Both ends share the same encode/decode modules
// - Granted frame flows with no added stalls
// - Re-request at frame end hands over without gap
// - Acknowledge follows the grant decision by one cycle
// - Both pending: alternate inputs frame by frame
// - Idle with both requesting: input one first
// - Downstream ready passes to granted input only
// - Ungranted input sees ack and ready low
// - Nothing granted: all acks and readies low
`timescale 1ns/1ps
module xga_top import xga_pkg::*; (
   // Arbiter clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Transmit direction clock and its aligned reset
   input wire logic tx_interface_clock,
   input wire logic tx_interface_reset_n,
   // Receive direction clock and its aligned reset
   input wire logic rx_interface_clock,
   input wire logic rx_interface_reset_n,
   // Transmit stream in
   input wire logic tx_s_valid,
   output logic tx_s_ready,
   input wire logic [63:0] tx_s_data,
   input wire logic [7:0] tx_s_keep,
   input wire logic tx_s_last,
   // Transmit lanes out
   output logic [63:0] tx_lane_data,
   output logic [7:0] tx_lane_control,
   // Receive lanes in
   input wire logic [63:0] rx_lane_data,
   input wire logic [7:0] rx_lane_control,
   // Receive stream out; lanes cannot be stalled, so no ready
   output logic rx_m_valid,
   output logic [63:0] rx_m_data,
   output logic [7:0] rx_m_keep,
   output logic rx_m_last,
   // Arbiter request and acknowledge, bit 0 is input one
   input wire logic [1:0] arb_req,
   output logic [1:0] arb_ack,
   // Arbiter stream inputs
   input wire logic [1:0] arb_s_valid,
   output logic [1:0] arb_s_ready,
   input wire logic [1:0][63:0] arb_s_data,
   input wire logic [1:0][7:0] arb_s_keep,
   input wire logic [1:0] arb_s_last,
   // Arbiter stream output
   output logic arb_m_valid,
   input wire logic arb_m_ready,
   output logic [63:0] arb_m_data,
   output logic [7:0] arb_m_keep,
   output logic arb_m_last
);

   // Lane bundles between the adapters and the pins
   xga_lane_if tx_lane ();
   xga_lane_if rx_lane ();

   // ---------------------------------------------------------------
   // Transmit adapter
   // ---------------------------------------------------------------

   // Stream and lanes share the interface clock, so no crossing
   // and the delay through the adapter is fixed
   xga_tx_enc u_tx (
      .clk (tx_interface_clock),
      .rst_n (tx_interface_reset_n),
      .s_valid (tx_s_valid),
      .s_data (tx_s_data),
      .s_keep (tx_s_keep),
      .s_last (tx_s_last),
      .s_ready (tx_s_ready),
      .lane (tx_lane.src)
   ); // Same encoder serves a MAC or PHY facing end

   // Lanes come straight from the encoder's registers
   assign tx_lane_data = tx_lane.d;
   assign tx_lane_control = tx_lane.c;

   // ---------------------------------------------------------------
   // Receive adapter
   // ---------------------------------------------------------------

   // Incoming lanes enter the bundle unchanged
   assign rx_lane.d = rx_lane_data;
   assign rx_lane.c = rx_lane_control;

   // Receive side on its own clock, separate from transmit
   xga_rx_dec u_rx (
      .clk (rx_interface_clock),
      .rst_n (rx_interface_reset_n),
      .lane (rx_lane.snk),
      .m_valid (rx_m_valid),
      .m_data (rx_m_data),
      .m_keep (rx_m_keep),
      .m_last (rx_m_last)
   ); // Same decoder serves a MAC or PHY facing end

   // ---------------------------------------------------------------
   // Frame arbiter
   // ---------------------------------------------------------------

   // Whole arbiter state: the one-hot grant, which is also the ack
   typedef struct packed {
      logic [1:0] gnt;
   } xga_arb_s_t;
   xga_arb_s_t q, n;

   logic eof; // Last beat of the granted frame accepted
   logic free; // Arbiter may decide this cycle

   // Decision logic; the grant only moves at a frame boundary
   always_comb begin
      n = q;
      eof = |(q.gnt & arb_s_valid & arb_s_last) & arb_m_ready;
      // Grant stays until its last beat is taken
      free = (q.gnt == 2'h0) || eof;
      if (free) begin
         if (q.gnt == 2'h0) begin
            // From idle input one wins a tie
            if (arb_req[0]) begin
               n.gnt = 2'h1;
            end else if (arb_req[1]) begin
               n.gnt = 2'h2;
            end else begin
               n.gnt = 2'h0;
            end
         end else if (&arb_req) begin
            // Both pending at frame end: turn to the other one
            n.gnt = ~q.gnt;
         end else begin
            // A re-raised request is taken at once, no idle cycle;
            // with no request at all the arbiter goes idle
            n.gnt = arb_req;
         end
      end
   end

   // Grant register; the ack shows the decision one cycle later
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   // Ack is the registered grant; ungranted input stays low
   assign arb_ack = q.gnt;

   // Back-pressure reaches only the granted input; the ready must be
   // a straight path or the stream would gain a bubble
   assign arb_s_ready = q.gnt & {2{arb_m_ready}};

   // Output follows the granted input with no register stage, so a
   // started frame runs at full rate
   assign arb_m_valid = |(q.gnt & arb_s_valid);
   assign arb_m_data = q.gnt[1] ? arb_s_data[1] : arb_s_data[0];
   assign arb_m_keep = q.gnt[1] ? arb_s_keep[1] : arb_s_keep[0];
   assign arb_m_last = q.gnt[1] ? arb_s_last[1] : arb_s_last[0];

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------

   // Helper: terminate character seen in any transmit lane
   logic [7:0] tx_term_lane;
   genvar gi;
   generate
      for (gi = 0; gi < XGA_LANES; gi++) begin : g_term
         assign tx_term_lane[gi] = tx_lane_control[gi] &&
            (tx_lane_data[gi*8 +: 8] == XGA_TERM);
      end
   endgenerate

   // Helper: frame end seen on the arbiter output
   logic arb_eof;
   assign arb_eof = arb_m_valid && arb_m_ready && arb_m_last;

   // A terminate is followed by two full idle words before anything
   property p_tx_gap;
      @(posedge tx_interface_clock) disable iff (!tx_interface_reset_n)
      (|tx_term_lane) |=> (tx_lane_control == XGA_ALL) [*2];
   endproperty
   a_tx_gap: assert property (p_tx_gap)
      else $error("transmit idle gap shorter than twelve bytes");

   // A start in lane 0 has no other control lane and the full preamble behind it
   property p_tx_sof;
      @(posedge tx_interface_clock) disable iff (!tx_interface_reset_n)
      (tx_lane_control[0] && tx_lane_data[7:0] == XGA_START) |->
         (tx_lane_control == XGA_LANE0) &&
         (tx_lane_data[63:8] == {XGA_SFD, {6{XGA_PRE}}});
   endproperty
   a_tx_sof: assert property (p_tx_sof)
      else $error("transmit start word malformed");

   // Lane 4 start and a full data word: a beat leaves two edges on
   property p_rx_lane4;
      @(posedge rx_interface_clock) disable iff (!rx_interface_reset_n)
      (rx_lane_control[4] && rx_lane_data[39:32] == XGA_START)
      ##1 (rx_lane_control == 8'h00) ##1 (rx_lane_control[3:0] == 4'h0)
      |=> ##1 rx_m_valid;
   endproperty
   a_rx_lane4: assert property (p_rx_lane4)
      else $error("lane four start not delivered");

   // From idle a single request is acked on the next edge
   property p_ack_next;
      @(posedge clk) disable iff (!arst_n)
      (arb_ack == 2'h0 && arb_req == 2'h2) |=> (arb_ack == 2'h2);
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("acknowledge late after grant");

   // From idle a tie goes to input one
   property p_prio;
      @(posedge clk) disable iff (!arst_n)
      (arb_ack == 2'h0 && arb_req == 2'h3) |=> (arb_ack == 2'h1);
   endproperty
   a_prio: assert property (p_prio)
      else $error("input one lost tie from idle");

   // Both pending at a frame end: the grant flips
   property p_alt;
      @(posedge clk) disable iff (!arst_n)
      (arb_eof && arb_req == 2'h3 && arb_ack != 2'h0) |=>
         (arb_ack == ~$past(arb_ack));
   endproperty
   a_alt: assert property (p_alt)
      else $error("arbiter did not alternate");

   // Re-request at frame end: new ack on the very next edge
   property p_b2b;
      @(posedge clk) disable iff (!arst_n)
      (arb_eof && arb_ack == 2'h1 && arb_req == 2'h1) |=>
         (arb_ack == 2'h1);
   endproperty
   a_b2b: assert property (p_b2b)
      else $error("back-to-back handover lost");

   // Grant does not move mid-frame
   property p_hold;
      @(posedge clk) disable iff (!arst_n)
      (arb_ack != 2'h0 && !arb_eof) |=> $stable(arb_ack);
   endproperty
   a_hold: assert property (p_hold)
      else $error("grant moved inside a frame");

   // Only the granted input sees ready, and only with downstream ready
   property p_ready;
      @(posedge clk) disable iff (!arst_n)
      $onehot0(arb_ack) &&
      ((arb_s_ready & ~arb_ack) == 2'h0) &&
      (arb_m_ready || arb_s_ready == 2'h0);
   endproperty
   a_ready: assert property (p_ready)
      else $error("ready reached an ungranted input");

   // No request while idle keeps everything low next cycle
   property p_idle;
      @(posedge clk) disable iff (!arst_n)
      (arb_ack == 2'h0 && arb_req == 2'h0) |=>
         (arb_ack == 2'h0 && arb_s_ready == 2'h0 && !arb_m_valid);
   endproperty
   a_idle: assert property (p_idle)
      else $error("arbiter not quiet when idle");

   // Granted valid data reaches the output in the same cycle
   property p_fwd;
      @(posedge clk) disable iff (!arst_n)
      (arb_ack == 2'h2 && arb_s_valid[1]) |->
         (arb_m_valid && arb_m_data == arb_s_data[1]);
   endproperty
   a_fwd: assert property (p_fwd)
      else $error("granted beat not forwarded");

endmodule : xga_top

/* File: design/xga_pkg.sv */
// Shared constants and types of the lane adapters and frame arbiter
package xga_pkg;
   // Lane control characters
   localparam logic [7:0] XGA_IDLE = 8'h07;
   localparam logic [7:0] XGA_START = 8'hFB;
   localparam logic [7:0] XGA_TERM = 8'hFD;
   localparam logic [7:0] XGA_ERR = 8'hFE;
   localparam logic [7:0] XGA_PRE = 8'h55;
   localparam logic [7:0] XGA_SFD = 8'hD5;
   // Word layout
   localparam int XGA_LANES = 8;
   localparam logic [7:0] XGA_ALL = 8'hFF;
   localparam logic [7:0] XGA_LANE0 = 8'h01;
   // Least idle gap in bytes, and whole idle words that cover it
   localparam int XGA_IFG_BYTES = 12;
   localparam int XGA_IFG_WORDS = (XGA_IFG_BYTES + XGA_LANES - 1) / XGA_LANES;
   localparam logic [1:0] XGA_GAP_LAST = 2'(XGA_IFG_WORDS - 1);
   // Interface clock rate in kHz
   localparam int XGA_LINK_KHZ = 156250;
   // Adapter states
   typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_TERM, TX_GAP} xga_tx_st_t;
   typedef enum logic [1:0] {RX_IDLE, RX_SKIP, RX_DATA, RX_FLUSH} xga_rx_st_t;
endpackage : xga_pkg

/* File: design/xga_lane_if.sv */
// One direction of 64-bit lane data with its eight control lines
`timescale 1ns/1ps
interface xga_lane_if;
   logic [63:0] d; // Lane data, byte i on bits 8i+7..8i
   logic [7:0] c; // Per-lane control flag
   modport src (output d, output c);
   modport snk (input d, input c);
endinterface : xga_lane_if

/* File: design/xga_tx_enc.sv */
// Stream to lane encoder: preamble, start, terminate and idle gap
`timescale 1ns/1ps
module xga_tx_enc import xga_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic s_valid,
   input wire logic [63:0] s_data,
   input wire logic [7:0] s_keep,
   input wire logic s_last,
   output logic s_ready,
   xga_lane_if.src lane
);
   typedef struct packed {
      xga_tx_st_t st;
      logic [1:0] gap;
      logic rdy;
      logic [63:0] d;
      logic [7:0] c;
   } xga_tx_s_t;
   xga_tx_s_t q, n;
   logic [8:0] k1; // Keep shifted up: k1[i] is keep of lane i-1

   // Next word; lanes default to idle so every gap cycle is clean
   always_comb begin
      n = q;
      k1 = {s_keep, 1'h1};
      n.d = {XGA_LANES{XGA_IDLE}};
      n.c = XGA_ALL;
      unique case (q.st)
         TX_IDLE: if (s_valid) begin
            // Start in lane 0, six preamble bytes, delimiter
            n.d = {XGA_SFD, {6{XGA_PRE}}, XGA_START};
            n.c = XGA_LANE0;
            n.st = TX_DATA;
            n.rdy = 1'h1;
         end
         TX_DATA: if (s_valid) begin
            n.d = s_data; // Beat goes out as plain data
            n.c = 8'h00;
            if (s_last) begin
               n.rdy = 1'h0;
               n.gap = XGA_GAP_LAST;
               n.st = (s_keep == XGA_ALL) ? TX_TERM : TX_GAP;
               // Empty lanes: terminate after last byte, idle above
               for (int i = 0; i < XGA_LANES; i++) begin
                  if (!s_keep[i]) begin
                     n.c[i] = 1'h1;
                     n.d[i*8 +: 8] = k1[i] ? XGA_TERM : XGA_IDLE;
                  end
               end
            end
         end else begin
            // Underrun inside a frame poisons it rather than hiding it
            n.d = {XGA_LANES{XGA_ERR}};
         end
         TX_TERM: begin
            n.d[7:0] = XGA_TERM; // Full last word: terminate word
            n.st = TX_GAP;
         end
         TX_GAP: begin
            // Whole idle words cover the least gap
            n.gap = q.gap - 2'h1;
            if (q.gap == 2'h0) n.st = TX_IDLE;
         end
      endcase
   end

   // Partial frames are dropped and lanes idle during reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{st: TX_IDLE, gap: 2'h0, rdy: 1'h0,
                d: {XGA_LANES{XGA_IDLE}}, c: XGA_ALL};
      end else begin
         q <= n;
      end
   end

   assign s_ready = q.rdy;
   assign lane.d = q.d;
   assign lane.c = q.c;
endmodule : xga_tx_enc

/* File: design/xga_rx_dec.sv */
// Lane to stream decoder: strips preamble, aligns lane 4 starts
`timescale 1ns/1ps
module xga_rx_dec import xga_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   xga_lane_if.snk lane,
   output logic m_valid,
   output logic [63:0] m_data,
   output logic [7:0] m_keep,
   output logic m_last
);
   typedef struct packed {
      xga_rx_st_t st;
      logic off4; // Frame started in lane 4
      logic [31:0] hd; // Upper half of the previous word
      logic [3:0] hc;
      logic [63:0] pd; // Staged word, sent once its end is known
      logic [7:0] pk;
      logic pv;
      logic ov;
      logic [63:0] od;
      logic [7:0] ok;
      logic ol;
   } xga_rx_s_t;
   xga_rx_s_t q, n;
   logic [63:0] cw;
   logic [7:0] cc, mask;
   logic seen, start0, start4;

   // One word is staged so a terminate in lane 0 can still mark last
   always_comb begin
      n = q;
      cw = q.off4 ? {lane.d[31:0], q.hd} : lane.d;
      cc = q.off4 ? {lane.c[3:0], q.hc} : lane.c;
      seen = 1'h0;
      mask = 8'h00;
      // Bytes ahead of the first control lane are frame data
      for (int i = 0; i < XGA_LANES; i++) begin
         seen = seen | cc[i];
         mask[i] = ~seen;
      end
      // Start found in lane 0 or lane 4
      start0 = lane.c[0] && (lane.d[7:0] == XGA_START);
      start4 = lane.c[4] && (lane.d[39:32] == XGA_START);
      n.ov = 1'h0;
      n.ol = 1'h0;
      n.ok = XGA_ALL;
      n.od = q.pd;
      n.hd = lane.d[63:32];
      n.hc = lane.c[7:4];
      unique case (q.st)
         RX_IDLE, RX_FLUSH: begin
            if (q.st == RX_FLUSH) begin
               n.ov = 1'h1; // Partial last word
               n.ok = q.pk;
               n.ol = 1'h1;
            end
            n.pv = 1'h0;
            n.st = RX_IDLE;
            // Preamble word is never delivered
            if (start0) begin
               n.st = RX_DATA;
               n.off4 = 1'h0;
            end else if (start4) begin
               n.st = RX_SKIP;
               n.off4 = 1'h1;
            end
         end
         RX_SKIP: n.st = RX_DATA; // Rest of preamble in lanes 0..3
         RX_DATA: begin
            n.ov = q.pv;
            if (cc == 8'h00) begin
               n.pd = cw;
               n.pv = 1'h1;
            end else if (cc[0]) begin
               n.ol = 1'h1; // Terminate in lane 0 ends staged word
               n.st = RX_IDLE;
            end else begin
               n.pd = cw;
               n.pk = mask;
               n.st = RX_FLUSH;
            end
         end
      endcase
   end

   // Reset drops any frame in progress
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign m_valid = q.ov;
   assign m_data = q.od;
   assign m_keep = q.ok;
   assign m_last = q.ol;
endmodule : xga_rx_dec

/* File: sim/xga_phy_model.sv */
// Line side model: loops transmit lanes back or plays injected words
`timescale 1ns/1ps
module xga_phy_model import xga_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [63:0] tx_d,
   input wire logic [7:0] tx_c,
   input wire logic inject,
   input wire logic [63:0] inj_d,
   input wire logic [7:0] inj_c,
   output logic [63:0] rx_d,
   output logic [7:0] rx_c
);
   // One word of line delay; lanes run on the shared interface clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // Idle line while held in reset
         rx_d <= {8{XGA_IDLE}};
         rx_c <= XGA_ALL;
      end else if (inject) begin
         // Bench-chosen words, e.g. a start in lane four
         rx_d <= inj_d;
         rx_c <= inj_c;
      end else begin
         // Plain loopback, so a framed word meets the receiver unchanged
         rx_d <= tx_d;
         rx_c <= tx_c;
      end
   end
endmodule : xga_phy_model

/* File: sim/tb_xga_top.sv */
// Self-checking bench of the lane adapters and the frame arbiter
`timescale 1ns/1ps
module tb_xga_top import xga_pkg::*; ;
   logic clk = 1'b0; // One clock feeds all three domains
   logic arst_n = 1'b0;
   logic tx_rst_n = 1'b0;
   logic rx_rst_n = 1'b0;
   logic tx_s_valid = 1'b0;
   logic tx_s_ready;
   logic [63:0] tx_s_data = 64'h0;
   logic [7:0] tx_s_keep = 8'hFF;
   logic tx_s_last = 1'b0;
   logic [63:0] tx_lane_data;
   logic [7:0] tx_lane_control;
   logic [63:0] rx_lane_data;
   logic [7:0] rx_lane_control;
   logic rx_m_valid, rx_m_last;
   logic [63:0] rx_m_data;
   logic [7:0] rx_m_keep;
   logic [1:0] arb_req = 2'b00;
   logic [1:0] arb_ack, arb_s_ready;
   logic [1:0] arb_s_valid = 2'b00;
   logic [1:0][63:0] arb_s_data = '0;
   logic [1:0][7:0] arb_s_keep = {8'hFF, 8'hFF};
   logic [1:0] arb_s_last = 2'b00;
   logic arb_m_valid, arb_m_last;
   logic arb_m_ready = 1'b0;
   logic [63:0] arb_m_data;
   logic [7:0] arb_m_keep;
   logic inject = 1'b0; // Line model plays bench words when high
   logic [71:0] inj = {XGA_ALL, {8{XGA_IDLE}}};
   logic [72:0] rxq[$]; // Received beats as {last, keep, data}
   int bad_count = 0;
   int checked = 0;

   // 200 MHz clock
   always #2.5 clk = ~clk;

   xga_top i_dut (.clk(clk), .arst_n(arst_n),
      .tx_interface_clock(clk), .tx_interface_reset_n(tx_rst_n),
      .rx_interface_clock(clk), .rx_interface_reset_n(rx_rst_n),
      .tx_s_valid(tx_s_valid), .tx_s_ready(tx_s_ready),
      .tx_s_data(tx_s_data), .tx_s_keep(tx_s_keep), .tx_s_last(tx_s_last),
      .tx_lane_data(tx_lane_data), .tx_lane_control(tx_lane_control),
      .rx_lane_data(rx_lane_data), .rx_lane_control(rx_lane_control),
      .rx_m_valid(rx_m_valid), .rx_m_data(rx_m_data),
      .rx_m_keep(rx_m_keep), .rx_m_last(rx_m_last),
      .arb_req(arb_req), .arb_ack(arb_ack), .arb_s_valid(arb_s_valid),
      .arb_s_ready(arb_s_ready), .arb_s_data(arb_s_data),
      .arb_s_keep(arb_s_keep), .arb_s_last(arb_s_last),
      .arb_m_valid(arb_m_valid), .arb_m_ready(arb_m_ready),
      .arb_m_data(arb_m_data), .arb_m_keep(arb_m_keep),
      .arb_m_last(arb_m_last));

   xga_phy_model i_phy (.clk(clk), .rst_n(rx_rst_n), .tx_d(tx_lane_data),
      .tx_c(tx_lane_control), .inject(inject), .inj_d(inj[63:0]),
      .inj_c(inj[71:64]), .rx_d(rx_lane_data), .rx_c(rx_lane_control));

   // Collect receive beats; each stands one cycle only
   always @(negedge clk) begin
      if (rx_m_valid === 1'b1) begin
         rxq.push_back({rx_m_last, rx_m_keep, rx_m_data});
      end
   end

   // Compare and count; unknowns never match
   task chk(input string what, input logic [72:0] seen,
            input logic [72:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Inputs change at the falling edge or 1 ns after it
   task tick;
      @(negedge clk);
   endtask : tick

   // Verdict and end of run
   task tally_and_finish;
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   // Two-beat frame out on the lanes, then looped back into the receiver
   task t_tx;
      int n;
      logic [63:0] a, b;
      a = 64'h0807060504030201;
      b = 64'h1817161514131211;
      rxq.delete();
      tx_s_valid = 1'b1;
      tx_s_data = a;
      tx_s_keep = 8'hFF;
      tx_s_last = 1'b0;
      n = 0;
      tick;
      while (tx_s_ready !== 1'b1 && n < 20) begin
         tick;
         n++;
      end
      if (n >= 20) begin
         chk("tx ready wait", 1'b0, 1'b1);
         tally_and_finish;
      end
      chk("tx start", {tx_lane_control, tx_lane_data},
         {XGA_LANE0, XGA_SFD, {6{XGA_PRE}}, XGA_START});
      tick;
      chk("tx data", {tx_lane_control, tx_lane_data}, {8'h00, a});
      tx_s_data = b;
      tx_s_keep = 8'h0F;
      tx_s_last = 1'b1;
      tick;
      chk("tx term", {tx_lane_control, tx_lane_data},
         {8'hF0, {3{XGA_IDLE}}, XGA_TERM, b[31:0]});
      chk("tx ready gap", tx_s_ready, 1'b0);
      tx_s_valid = 1'b0;
      tx_s_last = 1'b0;
      // Terminate and three idle bytes after the end plus two idle words exceed twelve
      repeat (2) begin
         tick;
         chk("tx gap", {tx_lane_control, tx_lane_data},
            {XGA_ALL, {8{XGA_IDLE}}});
      end
      repeat (8) tick;
      chk("rx count", rxq.size(), 73'd2);
      chk("rx beat 0", rxq[0], {1'b0, 8'hFF, a});
      // Lanes past keep still carry the line's terminate and idles
      chk("rx beat 1", rxq[1],
         {1'b1, 8'h0F, {3{XGA_IDLE}}, XGA_TERM, b[31:0]});
      $display("test tx_frame done");
   endtask : t_tx

   // Receive frame whose start sits in lane four
   task t_rx4;
      logic [63:0] p;
      logic [71:0] w[4];
      p = 64'h2827262524232221;
      w[0] = {XGA_ALL, {8{XGA_IDLE}}};
      w[1] = {8'h1F, {3{XGA_PRE}}, XGA_START, {4{XGA_IDLE}}};
      w[2] = {8'h00, p[31:0], XGA_SFD, {3{XGA_PRE}}};
      w[3] = {8'hF0, {3{XGA_IDLE}}, XGA_TERM, p[63:32]};
      rxq.delete();
      inject = 1'b1;
      foreach (w[i]) begin
         inj = w[i];
         tick;
      end
      inj = w[0];
      repeat (8) tick;
      inject = 1'b0;
      chk("rx4 count", rxq.size(), 73'd1);
      chk("rx4 beat", rxq[0], {1'b1, 8'hFF, p});
      $display("test rx_lane4 done");
   endtask : t_rx4

   // Tie from idle, stall, back-to-back handover, release
   task t_arb;
      arb_req = 2'b11; // Both sources hold data
      #1;
      chk("ack idle", arb_ack, 2'b00);
      tick;
      chk("ack tie", arb_ack, 2'b01);
      arb_s_valid = 2'b01; // Source one drives only once acknowledged
      arb_s_data[0] = 64'hA1;
      #1;
      chk("ready stalled", arb_s_ready, 2'b00);
      chk("m beat", {arb_m_valid, arb_m_keep, arb_m_data},
         {1'b1, 8'hFF, 64'hA1});
      tick;
      chk("ack held", arb_ack, 2'b01);
      arb_m_ready = 1'b1;
      #1;
      chk("ready granted", arb_s_ready, 2'b01);
      tick;
      arb_s_data[0] = 64'hA2;
      arb_s_last = 2'b01;
      #1;
      chk("m last", {arb_m_valid, arb_m_last}, 2'b11);
      tick;
      chk("ack swap", arb_ack, 2'b10);
      arb_s_valid = 2'b10;
      arb_s_last = 2'b10;
      arb_s_data[1] = 64'hB1;
      arb_s_keep[1] = 8'h0F;
      arb_req = 2'b01; // Source two holds nothing more
      #1;
      chk("m two", {arb_m_valid, arb_m_last, arb_m_keep, arb_m_data},
         {2'b11, 8'h0F, 64'hB1});
      chk("ready two", arb_s_ready, 2'b10);
      tick;
      chk("ack back", arb_ack, 2'b01);
      arb_s_valid = 2'b01;
      arb_s_last = 2'b01;
      // Source one still holds a frame, so its request stays up
      tick;
      chk("ack b2b", arb_ack, 2'b01);
      arb_req = 2'b00;
      tick;
      arb_s_valid = 2'b00;
      #1;
      chk("ack none", arb_ack, 2'b00);
      chk("ready none", arb_s_ready, 2'b00);
      arb_req = 2'b10; // Lone request from idle
      tick;
      chk("ack lone", arb_ack, 2'b10);
      arb_req = 2'b00;
      arb_s_valid = 2'b10;
      arb_s_last = 2'b10;
      tick;
      arb_s_valid = 2'b00;
      #1;
      chk("ack end", arb_ack, 2'b00);
      $display("test arbiter done");
   endtask : t_arb

   // Transmit reset in mid-frame idles the lanes
   task t_rst;
      tx_s_valid = 1'b1;
      tx_s_keep = 8'hFF;
      repeat (3) tick;
      tx_rst_n = 1'b0;
      #1;
      chk("rst lanes", {tx_lane_control, tx_lane_data},
         {XGA_ALL, {8{XGA_IDLE}}});
      chk("rst ready", tx_s_ready, 1'b0);
      tick;
      tx_s_valid = 1'b0;
      tx_rst_n = 1'b1;
      repeat (2) tick;
      chk("rst after", {tx_lane_control, tx_lane_data},
         {XGA_ALL, {8{XGA_IDLE}}});
      $display("test tx_reset done");
   endtask : t_rst

   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      tick;
      arst_n = 1'b1;
      tx_rst_n = 1'b1;
      rx_rst_n = 1'b1;
      tick;
      t_tx;
      t_rx4;
      t_arb;
      t_rst;
      tally_and_finish;
   end
endmodule : tb_xga_top
